// >>> inc/stack_core_pkg.sv
// Constants, carriers and state of the 16-bit two-stack core.
// Assumes a single clock domain and an asynchronous active-low reset.
package stack_core_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int DATA_W      = 16;
    localparam int PAGE_W      = 4;
    localparam int RS_PAGE_W   = 5;
    localparam int OFS_W       = 15;
    localparam int MADDR_W     = 19;
    localparam int PADDR_W     = 3;
    localparam int DEPTH_LARGE = 256;
    localparam int DEPTH_SMALL = 64;

    // ****************************************
    // Opcodes, bits [15:12] of an instruction
    // ****************************************
    localparam logic [3:0] OP_ALU   = 4'h0;
    localparam logic [3:0] OP_LIT   = 4'h1;
    localparam logic [3:0] OP_DUP   = 4'h2;
    localparam logic [3:0] OP_DROP  = 4'h3;
    localparam logic [3:0] OP_SWAP  = 4'h4;
    localparam logic [3:0] OP_TOR   = 4'h5;
    localparam logic [3:0] OP_FROMR = 4'h6;
    localparam logic [3:0] OP_CALL  = 4'h7;
    localparam logic [3:0] OP_RET   = 4'h8;
    localparam logic [3:0] OP_JMP   = 4'h9;
    localparam logic [3:0] OP_JZ    = 4'hA;
    localparam logic [3:0] OP_FETCH = 4'hB;
    localparam logic [3:0] OP_STORE = 4'hC;
    localparam logic [3:0] OP_IORD  = 4'hD;
    localparam logic [3:0] OP_IOWR  = 4'hE;

    // ****************************************
    // ALU selects
    // ****************************************
    localparam logic [2:0] ALU_ADD = 3'h0;
    localparam logic [2:0] ALU_SUB = 3'h1;
    localparam logic [2:0] ALU_AND = 3'h2;
    localparam logic [2:0] ALU_OR  = 3'h3;
    localparam logic [2:0] ALU_XOR = 3'h4;
    localparam logic [2:0] ALU_SHL = 3'h5;
    localparam logic [2:0] ALU_SHR = 3'h6;
    localparam logic [2:0] ALU_NOT = 3'h7;

    typedef enum logic [1:0] {
        PH_EXEC = 2'b00,
        PH_MEM  = 2'b01,
        PH_IO   = 2'b11
    } phase_t;

    typedef struct packed {
        logic [MADDR_W-1:0] addr;
        logic               rd;
        logic               wr;
        logic               upperStrobe;
        logic               lowerStrobe;
        logic [DATA_W-1:0]  wdata;
    } mem_req_t;

    typedef struct packed {
        logic [PADDR_W-1:0] addr;
        logic               rd;
        logic               wr;
        logic [DATA_W-1:0]  wdata;
    } periph_req_t;

    typedef struct packed {
        logic psOverflow;
        logic psUnderflow;
        logic rsOverflow;
        logic rsUnderflow;
    } stack_err_t;

    typedef struct packed {
        phase_t                pha;
        logic [DATA_W-1:0]    pend;
        logic [OFS_W-1:0]     pc;
        logic [PAGE_W-1:0]    page;
        logic [DATA_W-1:0]    top;
        logic [DATA_W-1:0]    nxt;
        logic [DATA_W-1:0]    rsWord;
        logic [RS_PAGE_W-1:0] rsPage;
        mem_req_t             mem;
        periph_req_t          io;
    } core_t;

    localparam core_t CORE_RST = '{pha: PH_EXEC, mem: '{rd: 1'b1, upperStrobe: 1'b1,
                                   lowerStrobe: 1'b1, default: '0}, default: '0};

endpackage

// >>> logic/stack_ctl.sv
// One on-chip LIFO: RAM part of a stack below the head registers.
// Push and pop never come in the same cycle; the core decodes them.
`timescale 1ns/1ps
module stack_ctl #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 256
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] rdData,
    output logic                  overflow,
    output logic                  underflow
);
    localparam int PW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] FULL = PW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               ptr;
        logic                        ovf;
        logic                        udf;
    } stk_t;

    stk_t          s_q;
    stk_t          s_d;
    logic [PW-1:0] rdIdx;

    // Element just below the head registers
    assign rdIdx  = s_q.ptr - 1'b1;
    assign rdData = (s_q.ptr == '0) ? '0 : s_q.mem[rdIdx];

    // ****************************************
    // Pointer and flags
    // ****************************************
    always_comb begin
        s_d = s_q;
        if (push) begin
            if (s_q.ptr == FULL) begin
                s_d.ovf = 1'b1;
            end else begin
                s_d.mem[s_q.ptr] = wrData;
                s_d.ptr = s_q.ptr + 1'b1;
            end
        end else if (pop) begin
            if (s_q.ptr == '0) begin
                s_d.udf = 1'b1;
            end else begin
                s_d.ptr = rdIdx;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Sticky until reset; no software path clears them
    assign overflow  = s_q.ovf;
    assign underflow = s_q.udf;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    ovf_flag_a: assert property (push && s_q.ptr == FULL |=> s_q.ovf && s_q.ptr == FULL)
        else $error("push on full stack not flagged");
    udf_flag_a: assert property (resetn && pop && !push && s_q.ptr == '0 |=> s_q.udf)
        else $error("pop on empty stack not flagged");
    depth_limit_a: assert property (s_q.ptr <= FULL)
        else $error("stack pointer beyond depth");
    stack_full_c: cover property (push && s_q.ptr == FULL);
endmodule

// >>> logic/stack_core.sv
// Core of a 16-bit two-stack processor: decode, head registers, buses.
// Memory answers in the cycle its address is shown; peripherals too.
// Instructions: [15:12] opcode, [11:0] operand.
//
// Function
// - Every instruction takes one or two cycles
// - Execute on fetch, no pipeline or cache
// - Stack heads in registers, rest in RAM
// - Stack control picks RAM slot, flags errors
// - Stack depth 256 or 64, a parameter
// - Parameter stack 16 bits, top and next
// - Top/next operations finish in one cycle
// - Return head is 16-bit word plus 5-bit page
// - Top moves between stacks in one cycle
// - Calls save return address; math uses parameters
// - Four separate buses run together: memory, peripheral and parameter stack are 16 bits, return stack 21 bits
// - Data words byte-swapped, instruction fetch not
// - Peripheral reads pass the ALU before push
// - 19-bit word address plus byte strobes
// - 3-bit peripheral address selects the device
// - Sixteen pages of 32K words each
// - Control registers reached over peripheral bus
// - Internal registers hidden from software
// - All internal paths one-directional, no tri-state
// - Memory access: data cycle, then fetch cycle
`timescale 1ns/1ps
module stack_core #(
    parameter int STACK_DEPTH = stack_core_pkg::DEPTH_LARGE
) (
    input  wire logic                                clk_sys,
    input  wire logic                                resetn,
    input  wire logic                                byteSwapEn,
    input  wire logic [stack_core_pkg::DATA_W-1:0]   memRData,
    input  wire logic [stack_core_pkg::DATA_W-1:0]   periphRData,
    output stack_core_pkg::mem_req_t                 memReq,
    output stack_core_pkg::periph_req_t              periphReq,
    output stack_core_pkg::stack_err_t               stackErr
);

    // ****************************************
    // Declarations
    // ****************************************
    stack_core_pkg::core_t                           s_q;
    stack_core_pkg::core_t                           s_d;
    logic [3:0]                                      op;
    logic [11:0]                                     imm;
    logic [3:0]                                      pendOp;
    logic [stack_core_pkg::OFS_W-1:0]                pcInc;
    logic [stack_core_pkg::DATA_W-1:0]               retAddr;
    logic [stack_core_pkg::DATA_W-1:0]               swapIn;
    logic [stack_core_pkg::DATA_W-1:0]               swapOut;
    logic [stack_core_pkg::DATA_W-1:0]               aluOut;
    logic [stack_core_pkg::DATA_W-1:0]               ioAluOut;
    logic                                            psPush;
    logic                                            psPop;
    logic                                            rsPush;
    logic                                            rsPop;
    logic [stack_core_pkg::DATA_W-1:0]               psRd;
    logic [stack_core_pkg::DATA_W+4:0]               rsRd;
    logic [stack_core_pkg::DATA_W+4:0]               rsWr;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] bswap(input logic en, input logic [15:0] w);
        bswap = en ? {w[7:0], w[15:8]} : w;
    endfunction

    function automatic logic [15:0] alu(input logic [2:0] sel, input logic [15:0] a,
                                        input logic [15:0] b);
        unique case (sel)
            stack_core_pkg::ALU_ADD: alu = a + b;
            stack_core_pkg::ALU_SUB: alu = a - b;
            stack_core_pkg::ALU_AND: alu = a & b;
            stack_core_pkg::ALU_OR:  alu = a | b;
            stack_core_pkg::ALU_XOR: alu = a ^ b;
            stack_core_pkg::ALU_SHL: alu = {a[14:0], 1'b0};
            stack_core_pkg::ALU_SHR: alu = {1'b0, a[15:1]};
            stack_core_pkg::ALU_NOT: alu = ~a;
        endcase
    endfunction

    // Instruction word is taken raw; only data words see the swapper
    assign op       = memRData[15:12];
    assign imm      = memRData[11:0];
    assign pendOp   = s_q.pend[15:12];
    assign pcInc    = s_q.pc + 15'h1;
    assign retAddr  = {1'b0, pcInc};
    assign swapIn   = bswap(byteSwapEn, memRData);
    assign swapOut  = bswap(byteSwapEn, s_q.nxt);
    assign aluOut   = alu(imm[2:0], s_q.nxt, s_q.top);
    // Peripheral data, with a 5-bit literal, through the ALU
    assign ioAluOut = alu(s_q.pend[6:4], periphRData,
                          {11'h000, s_q.pend[11:7]});
    assign rsWr     = {s_q.rsPage, s_q.rsWord};

    // ****************************************
    // Stack RAMs: two of the four data buses
    // ****************************************
    stack_ctl #(
        .WIDTH (stack_core_pkg::DATA_W),
        .DEPTH (STACK_DEPTH)
    ) paramStack (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .push      (psPush),
        .pop       (psPop),
        .wrData    (s_q.nxt),
        .rdData    (psRd),
        .overflow  (stackErr.psOverflow),
        .underflow (stackErr.psUnderflow)
    );

    stack_ctl #(
        .WIDTH (stack_core_pkg::DATA_W + stack_core_pkg::RS_PAGE_W),
        .DEPTH (STACK_DEPTH)
    ) returnStack (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .push      (rsPush),
        .pop       (rsPop),
        .wrData    (rsWr),
        .rdData    (rsRd),
        .overflow  (stackErr.rsOverflow),
        .underflow (stackErr.rsUnderflow)
    );

    // ****************************************
    // Decode and execute
    // ****************************************
    always_comb begin
        s_d         = s_q;
        psPush      = 1'b0;
        psPop       = 1'b0;
        rsPush      = 1'b0;
        rsPop       = 1'b0;
        s_d.io.rd   = 1'b0;
        s_d.io.wr   = 1'b0;
        s_d.mem.rd  = 1'b1;
        s_d.mem.wr  = 1'b0;
        unique case (s_q.pha)
            stack_core_pkg::PH_EXEC: begin
                s_d.pc   = pcInc;
                s_d.pend = memRData;
                unique case (op)
                    stack_core_pkg::OP_ALU: begin
                        s_d.top = aluOut;
                        s_d.nxt = psRd;
                        psPop   = 1'b1;
                    end
                    stack_core_pkg::OP_LIT: begin
                        s_d.top = {4'h0, imm};
                        s_d.nxt = s_q.top;
                        psPush  = 1'b1;
                    end
                    stack_core_pkg::OP_DUP: begin
                        s_d.nxt = s_q.top;
                        psPush  = 1'b1;
                    end
                    stack_core_pkg::OP_DROP: begin
                        s_d.top = s_q.nxt;
                        s_d.nxt = psRd;
                        psPop   = 1'b1;
                    end
                    stack_core_pkg::OP_SWAP: begin
                        s_d.top = s_q.nxt;
                        s_d.nxt = s_q.top;
                    end
                    stack_core_pkg::OP_TOR: begin
                        s_d.rsWord = s_q.top;
                        s_d.rsPage = {1'b0, s_q.page};
                        rsPush     = 1'b1;
                        s_d.top    = s_q.nxt;
                        s_d.nxt    = psRd;
                        psPop      = 1'b1;
                    end
                    stack_core_pkg::OP_FROMR: begin
                        s_d.top                  = s_q.rsWord;
                        s_d.nxt                  = s_q.top;
                        psPush                   = 1'b1;
                        {s_d.rsPage, s_d.rsWord} = rsRd;
                        rsPop                    = 1'b1;
                    end
                    stack_core_pkg::OP_CALL: begin
                        s_d.rsWord = retAddr;
                        s_d.rsPage = {1'b0, s_q.page};
                        rsPush     = 1'b1;
                        s_d.pc     = {3'h0, imm};
                    end
                    stack_core_pkg::OP_RET: begin
                        s_d.pc                   = s_q.rsWord[14:0];
                        s_d.page                 = s_q.rsPage[3:0];
                        {s_d.rsPage, s_d.rsWord} = rsRd;
                        rsPop                    = 1'b1;
                    end
                    stack_core_pkg::OP_JMP: begin
                        s_d.pc = {3'h0, imm};
                    end
                    stack_core_pkg::OP_JZ: begin
                        if (s_q.top == '0) begin
                            s_d.pc = {3'h0, imm};
                        end
                        s_d.top = s_q.nxt;
                        s_d.nxt = psRd;
                        psPop   = 1'b1;
                    end
                    stack_core_pkg::OP_FETCH: begin
                        s_d.pha = stack_core_pkg::PH_MEM;
                    end
                    stack_core_pkg::OP_STORE: begin
                        s_d.pha       = stack_core_pkg::PH_MEM;
                        s_d.mem.rd    = 1'b0;
                        s_d.mem.wr    = 1'b1;
                        s_d.mem.wdata = swapOut;
                        s_d.top       = s_q.nxt;
                        s_d.nxt       = psRd;
                        psPop         = 1'b1;
                    end
                    stack_core_pkg::OP_IORD: begin
                        s_d.pha     = stack_core_pkg::PH_IO;
                        s_d.io.addr = imm[2:0];
                        s_d.io.rd   = 1'b1;
                    end
                    stack_core_pkg::OP_IOWR: begin
                        // Control registers sit on this bus, not in the core
                        s_d.io.addr  = imm[2:0];
                        s_d.io.wr    = 1'b1;
                        s_d.io.wdata = s_q.top;
                        s_d.top      = s_q.nxt;
                        s_d.nxt      = psRd;
                        psPop        = 1'b1;
                    end
                    default: begin
                        s_d.pc = pcInc;
                    end
                endcase
                // Data cycle shows data address, else next fetch
                if (s_d.pha == stack_core_pkg::PH_MEM) begin
                    s_d.mem.addr = {s_q.page, s_q.top[14:0]};
                end else begin
                    s_d.mem.addr = {s_d.page, s_d.pc};
                end
            end
            stack_core_pkg::PH_MEM: begin
                if (pendOp == stack_core_pkg::OP_FETCH) begin
                    s_d.top = swapIn;
                end
                s_d.mem.addr = {s_q.page, s_q.pc};
                s_d.pha      = stack_core_pkg::PH_EXEC;
            end
            stack_core_pkg::PH_IO: begin
                s_d.top = ioAluOut;
                s_d.nxt = s_q.top;
                psPush  = 1'b1;
                s_d.pha = stack_core_pkg::PH_EXEC;
            end
            default: begin
                s_d.pha = stack_core_pkg::PH_EXEC;
            end
        endcase
        // Word accesses only; both halves strobed
        s_d.mem.upperStrobe = s_d.mem.rd | s_d.mem.wr;
        s_d.mem.lowerStrobe = s_d.mem.rd | s_d.mem.wr;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= stack_core_pkg::CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs: bus requests here; stack error flags leave straight from the stack controls
    // ****************************************
    assign memReq    = s_q.mem;
    assign periphReq = s_q.io;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic execOp;
    // Gated by reset so the release edge starts no attempt
    assign execOp = resetn && (s_q.pha == stack_core_pkg::PH_EXEC);

    two_cycle_a: assert property (s_q.pha != stack_core_pkg::PH_EXEC
        |=> s_q.pha == stack_core_pkg::PH_EXEC)
        else $error("instruction took more than two cycles");
    fetch_after_data_a: assert property (execOp && op == stack_core_pkg::OP_FETCH
        |=> s_q.mem.addr == {$past(s_q.page), $past(s_q.top[14:0])}
        ##1 s_q.mem.addr == {s_q.page, s_q.pc} && s_q.mem.rd)
        else $error("memory access cycle order wrong");
    jump_now_a: assert property (execOp && op == stack_core_pkg::OP_JMP
        |=> s_q.mem.addr == {$past(s_q.page), 3'h0, $past(imm)})
        else $error("jump target not fetched next");
    dup_one_a: assert property (execOp && op == stack_core_pkg::OP_DUP
        |=> s_q.top == $past(s_q.top) && s_q.nxt == $past(s_q.top))
        else $error("dup did not finish in one cycle");
    to_return_a: assert property (execOp && op == stack_core_pkg::OP_TOR
        |=> s_q.rsWord == $past(s_q.top) && s_q.top == $past(s_q.nxt))
        else $error("top not moved to return head");
    call_save_a: assert property (execOp && op == stack_core_pkg::OP_CALL
        |=> s_q.rsWord == $past(retAddr) && s_q.rsPage == {1'b0, $past(s_q.page)})
        else $error("call lost return address");
    swap_data_a: assert property (s_q.pha == stack_core_pkg::PH_MEM
        && pendOp == stack_core_pkg::OP_FETCH |=> s_q.top == $past(swapIn))
        else $error("fetched data not byte-swapped as set");
    io_alu_a: assert property (s_q.pha == stack_core_pkg::PH_IO
        |=> s_q.top == $past(ioAluOut) && s_q.nxt == $past(s_q.top))
        else $error("peripheral read skipped the ALU");
    strobe_pair_a: assert property (s_q.mem.rd || s_q.mem.wr
        |-> s_q.mem.upperStrobe && s_q.mem.lowerStrobe)
        else $error("byte strobes missing on access");
    io_addr_a: assert property (execOp && op == stack_core_pkg::OP_IOWR
        |=> s_q.io.wr && s_q.io.addr == $past(imm[2:0])
        ##1 s_q.io.wr == $past(execOp && op == stack_core_pkg::OP_IOWR))
        else $error("peripheral write address or pulse wrong");
    push_move_a: assert property (execOp && op == stack_core_pkg::OP_LIT
        |-> psPush ##1 s_q.nxt == $past(s_q.top))
        else $error("push did not shift top into next");
    swap_one_a: assert property (execOp && op == stack_core_pkg::OP_SWAP
        |=> s_q.top == $past(s_q.nxt) && s_q.nxt == $past(s_q.top))
        else $error("swap did not finish in one cycle");
    from_return_a: assert property (execOp && op == stack_core_pkg::OP_FROMR
        |=> s_q.top == $past(s_q.rsWord) && s_q.nxt == $past(s_q.top))
        else $error("return head not moved to top");
    ret_resume_a: assert property (execOp && op == stack_core_pkg::OP_RET
        |=> s_q.mem.addr == {$past(s_q.rsPage[3:0]), $past(s_q.rsWord[14:0])})
        else $error("return did not resume at saved address");
    branch_now_a: assert property (execOp && op == stack_core_pkg::OP_JZ
        |=> s_q.mem.addr == ($past(s_q.top) == '0 ? {$past(s_q.page), 3'h0, $past(imm)}
                                                   : {$past(s_q.page), $past(pcInc)}))
        else $error("branch target not fetched next");

    call_c:  cover property (execOp && op == stack_core_pkg::OP_CALL);
    fetch_c: cover property (s_q.pha == stack_core_pkg::PH_MEM
                             && pendOp == stack_core_pkg::OP_FETCH);
    store_c: cover property (execOp && op == stack_core_pkg::OP_STORE);
    ioread_c: cover property (s_q.pha == stack_core_pkg::PH_IO);

endmodule

// >>> sim/core_partner.sv
// Partner model: zero-wait word memory and peripheral devices for stack_core.
// Assumes the bench preloads mem while reset is held.
`timescale 1ns/1ps
module core_partner (
    input  wire logic                         clk_sys,
    input  wire stack_core_pkg::mem_req_t     memReq,
    input  wire stack_core_pkg::periph_req_t  periphReq,
    output logic [stack_core_pkg::DATA_W-1:0] memRData,
    output logic [stack_core_pkg::DATA_W-1:0] periphRData
);
    localparam logic [15:0] IO_VALUE = 16'h1230;
    logic [15:0] mem [0:511];
    logic [15:0] ioSeen [0:7];
    logic [2:0]  ioRdAddr;
    logic [15:0] noise = 16'hA5C3;

    // Undriven cycles show a changing pattern, never a stale word
    always @(posedge clk_sys) begin
        noise <= {noise[14:0], noise[15] ^ noise[13]};
        if (memReq.wr && memReq.upperStrobe && memReq.lowerStrobe) begin
            mem[memReq.addr[8:0]] <= memReq.wdata;
        end
        if (periphReq.wr) begin
            ioSeen[periphReq.addr] <= periphReq.wdata;
        end
        if (periphReq.rd) begin
            ioRdAddr <= periphReq.addr;
        end
    end
    assign memRData    = memReq.rd ? mem[memReq.addr[8:0]] : noise;
    assign periphRData = periphReq.rd ? IO_VALUE : ~noise;
endmodule

// >>> sim/stack_core_tb.sv
// Self-checking bench for stack_core with the small stack depth.
// Assumes core_partner answers memory and peripheral requests.
`timescale 1ns/1ps
module stack_core_tb;
    logic                        clk_sys;
    logic                        resetn;
    logic                        byteSwapEn;
    logic [15:0]                 memRData;
    logic [15:0]                 periphRData;
    stack_core_pkg::mem_req_t    memReq;
    stack_core_pkg::periph_req_t periphReq;
    stack_core_pkg::stack_err_t  stackErr;
    int                          bad_count = 0;
    int                          compares = 0;
    int                          cycles = 0;

    stack_core #(.STACK_DEPTH(stack_core_pkg::DEPTH_SMALL)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .byteSwapEn(byteSwapEn), .memRData(memRData),
        .periphRData(periphRData), .memReq(memReq), .periphReq(periphReq), .stackErr(stackErr));
    core_partner mdl (.clk_sys(clk_sys), .memReq(memReq), .periphReq(periphReq),
        .memRData(memRData), .periphRData(periphRData));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] want, input string what);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic restart(input logic swap, input logic [15:0] prog [$]);
        @(posedge clk_sys);
        resetn     <= 1'b0;
        byteSwapEn <= swap;
        for (int i = 0; i < 512; i++) mdl.mem[i] = 16'hF000;
        foreach (prog[i]) mdl.mem[i] = prog[i];
        repeat (16) @(posedge clk_sys);
        check(64'(memReq), 64'h0000_0000_000B_0000, "reset bus");
        check(64'(periphReq), 64'h0, "reset io");
        check(64'(stackErr), 64'h0, "reset flags");
        resetn <= 1'b1;
    endtask

    // Store, fetch, ALU-passed read, call and return, in both byte orders
    task automatic data_paths();
        for (int s = 0; s < 2; s++) begin
            restart(s[0], {16'h1034, 16'h1100, 16'hC000, 16'h1100, 16'hB000, 16'hE005,
                16'hD182, 16'hE006, 16'h700B, 16'hE007, 16'h900A, 16'h1077, 16'h8000});
            repeat (60) @(posedge clk_sys);
            check(64'(mdl.mem[256]), s ? 64'h3400 : 64'h0034, "stored word");
            check(64'(mdl.ioSeen[5]), 64'h0034, "fetched word");
            check(64'(mdl.ioSeen[6]), 64'h1233, "read through alu");
            check(64'(mdl.ioRdAddr), 64'h2, "read address");
            check(64'(mdl.ioSeen[7]), 64'h0077, "after return");
            check(64'(stackErr), 64'h0, "no errors");
        end
    endtask

    // Arithmetic, swap, moves between stacks and both branch outcomes
    task automatic stack_moves();
        restart(1'b0, {16'h1000, 16'h1005, 16'h2000, 16'h0000, 16'h1003, 16'h0001, 16'h1009,
            16'h4000, 16'h5000, 16'h6000, 16'hE001, 16'hA00E, 16'hA00E, 16'hE001, 16'h900E});
        repeat (40) @(posedge clk_sys);
        check(64'(mdl.ioSeen[1]), 64'h0007, "stack moves");
        check(64'(stackErr), 64'h0, "no move errors");
    endtask

    // Endless pushes: no flag up to 64 deep, overflow on the next push
    task automatic overflow();
        restart(1'b0, {16'h1001, 16'h9000});
        repeat (128) @(posedge clk_sys);
        check(64'(stackErr), 64'h0, "early overflow");
        repeat (2) @(posedge clk_sys);
        check(64'(stackErr), 64'h8, "overflow flag");
        restart(1'b0, {16'h7000});
        repeat (65) @(posedge clk_sys);
        check(64'(stackErr), 64'h0, "early return overflow");
        @(posedge clk_sys);
        check(64'(stackErr), 64'h2, "return overflow flag");
    endtask

    // Drop and return on empty stacks
    task automatic underflow();
        restart(1'b0, {16'h3000, 16'h8000});
        repeat (20) @(posedge clk_sys);
        check(64'(stackErr), 64'h5, "underflow flags");
    endtask

    initial begin
        resetn     = 1'b0;
        byteSwapEn = 1'b0;
        data_paths();
        stack_moves();
        overflow();
        underflow();
        finish_test();
    end
endmodule
